// >>> bench/srco_exec_asserts.sv
// Purpose: Timing and flag checks for the execution unit
// Assumes: Sees only the unit's ports, one clock domain
// Notes: Borrow is judged by adding subtrahend and carry back to the result
`timescale 1ns/1ps
module srco_exec_asserts import srco_pkg::*; #(
  parameter int PCW = PC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Handshake and stack
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic instr_ready,
  input wire logic done,
  input wire logic [PCW-1:0] stack_top,
  input wire logic stack_pop,
  // State
  input wire logic [NIB_W-1:0] accumulator,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic [PCW-1:0] pc
);
  logic tk;
  // Accept edge
  assign tk = instr_valid && instr_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // Subtracts: ready low two cycles, then result with borrow
  // ****
  property p_sub(logic hit, logic [3:0] sb);
    hit |=> !instr_ready [*2] ##1 (done && carry_flag ==
      ((5'(accumulator) + 5'($past(sb, 3)) + 5'($past(carry_flag, 3))) < 5'h10));
  endproperty
  AST_MEM_SUB: assert property (p_sub(tk && instr[15:7] == OP_SUB_MEM_ACC, accumulator))
    else $error("memory subtract result or timing wrong");
  AST_IMM_SUB: assert property (p_sub(tk && instr[15:8] == OP_SUB_IMM_ACC, instr[7:4]))
    else $error("immediate subtract result or timing wrong");
  AST_MEM_WB: assert property (p_sub(tk && instr[15:7] == OP_SUB_MEM_WB, accumulator))
    else $error("write-back memory subtract wrong");
  AST_IMM_WB: assert property (p_sub(tk && instr[15:8] == OP_SUB_IMM_WB, instr[7:4]))
    else $error("write-back immediate subtract wrong");
  AST_RETURN: assert property (tk && instr[15:9] == OP_RETURN |->
    stack_pop ##1 (done && pc == $past(stack_top))) else $error("return did not reload pc");
  AST_SET_CARRY: assert property (tk && instr[15:3] == OP_SET_CARRY |=>
    done && carry_flag && $stable(accumulator) && $stable(zero_flag))
    else $error("set carry wrong");
  AST_ZERO: assert property (done && !$past(instr_ready) |->
    zero_flag == (accumulator == 4'h0)) else $error("zero flag wrong after subtract");
  // Main scenarios reached
  cover property (tk && instr[15:9] == OP_RETURN);
  cover property (done && zero_flag);
  cover property (done && !carry_flag);
endmodule
bind srco_exec srco_exec_asserts #(.PCW(PCW)) u_chk (.clk(clk), .rst(rst),
  .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .done(done),
  .stack_top(stack_top), .stack_pop(stack_pop), .accumulator(accumulator),
  .carry_flag(carry_flag), .zero_flag(zero_flag), .pc(pc));

// >>> bench/srco_exec_tb.sv
// Purpose: Directed bench for the execution unit
// Assumes: Inputs driven on the falling edge
// Notes: A local model of memory and flags predicts every subtract
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module srco_exec_tb;
  import srco_pkg::*;
  logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, load_en = 1'b0;
  logic [INSTR_W-1:0] instr = '0;
  logic [PC_W-1:0] stack_top = '0, pc;
  logic [ADDR_W-1:0] load_addr = '0;
  logic [NIB_W-1:0] load_data = '0, accumulator, m_acc = 4'h0, mem_m [128];
  logic instr_ready, done, illegal, stack_pop, carry_flag, zero_flag;
  logic m_cf = 1'b0, m_zf = 1'b0;
  int err_count = 0, samples_checked = 0;
  // Clock at 100 MHz
  always #5 clk = ~clk;
  srco_exec u_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .done(done), .illegal(illegal), .stack_top(stack_top),
    .stack_pop(stack_pop), .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .accumulator(accumulator), .carry_flag(carry_flag), .zero_flag(zero_flag), .pc(pc));
  // ****
  // Shared tasks
  // ****
  task automatic stop_test();
    $display("Checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Preload only while idle, memory has no reset
  task automatic load(input logic [6:0] a, input logic [3:0] d);
    load_en = 1'b1;
    load_addr = a;
    load_data = d;
    mem_m[a] = d;
    @(negedge clk);
    load_en = 1'b0;
    // Idle cycle so a following load never re-raises the strobe in one step
    @(negedge clk);
  endtask
  task automatic run(input logic [15:0] w, input int lat, input logic ill);
    int n;
    instr = w;
    instr_valid = 1'b1;
    #1 `CHK(stack_pop, w[15:9] == OP_RETURN)
    @(negedge clk);
    instr_valid = 1'b0;
    `CHK(instr_ready, lat == 1)
    n = 1;
    while (done !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, lat)
    `CHK(illegal, ill)
    if (n >= 6) stop_test();
    @(negedge clk);
  endtask
  task automatic chk_state();
    `CHK(accumulator, m_acc)
    `CHK(carry_flag, m_cf)
    `CHK(zero_flag, m_zf)
  endtask
  // Bit 10 marks immediate forms, bit 8 marks write-back
  task automatic sub(input logic [15:0] w);
    logic [6:0] a;
    logic [3:0] sb;
    logic [4:0] d;
    a = w[10] ? {3'h0, w[3:0]} : w[6:0];
    sb = w[10] ? w[7:4] : m_acc;
    d = {1'b0, mem_m[a]} - {1'b0, sb} - {4'h0, m_cf};
    m_acc = d[3:0];
    m_cf = !d[4];
    m_zf = d[3:0] == 4'h0;
    if (w[8]) mem_m[a] = d[3:0];
    run(w, 3, 1'b0);
    chk_state();
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_ret_setc();
    stack_top = 11'h5A3;
    run({7'h01, 9'h1FF}, 1, 1'b0);
    `CHK(pc, 11'h5A3)
    run({13'h0A00, 3'h7}, 1, 1'b0);
    m_cf = 1'b1;
    chk_state();
    run(16'hFFFF, 1, 1'b1);
    chk_state();
    $display("return and set carry test done");
  endtask
  task automatic t_mem();
    load(7'h05, 4'h3);
    load(7'h7F, 4'h1);
    load(7'h40, 4'h9);
    sub({9'h014, 7'h05});
    sub({9'h014, 7'h7F});
    sub({9'h016, 7'h40});
    sub({9'h014, 7'h40});
    $display("memory subtract test done");
  endtask
  task automatic t_imm();
    load(7'h03, 4'h7);
    load(7'h0F, 4'h2);
    sub({8'h0E, 4'h6, 4'h3});
    sub({8'h0F, 4'h5, 4'hF});
    sub({9'h014, 7'h0F});
    $display("immediate subtract test done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_ret_setc();
    t_mem();
    t_imm();
    stop_test();
  end
endmodule

// >>> core/srco_data_mem.sv
// Purpose: Data memory nibble store with registered read data
// Assumes: One write port and one read port on the same clock
// Notes: Contents are not reset, as in a real RAM
`timescale 1ns/1ps
module srco_data_mem #(
  parameter int WIDTH = srco_pkg::NIB_W,
  parameter int AW = srco_pkg::ADDR_W
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_q
);
  import srco_pkg::*;

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // ********************************************************************
  // Storage
  // ********************************************************************
  // Read data is registered so it maps onto block RAM
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule

// >>> core/srco_exec.sv
// Purpose: Execution of return, subtract-with-borrow and set-carry instructions
// Assumes: One instruction offered at a time with a valid/ready handshake
// Notes: Subtracts take three clocks (memory read is registered), others one
//   Outside loads are dropped while a subtract is in flight
`timescale 1ns/1ps
module srco_exec #(
  parameter int PCW = srco_pkg::PC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction handshake
  input wire logic instr_valid,
  input wire logic [srco_pkg::INSTR_W-1:0] instr,
  output logic instr_ready,
  output logic done,
  output logic illegal,
  // Subroutine stack
  input wire logic [PCW-1:0] stack_top,
  output logic stack_pop,
  // Data memory load from the rest of the core
  input wire logic load_en,
  input wire logic [srco_pkg::ADDR_W-1:0] load_addr,
  input wire logic [srco_pkg::NIB_W-1:0] load_data,
  // Architectural state
  output logic [srco_pkg::NIB_W-1:0] accumulator,
  output logic carry_flag,
  output logic zero_flag,
  output logic [PCW-1:0] pc
);
  import srco_pkg::*;

  // ********************************************************************
  // State and internal nets
  // ********************************************************************
  srco_state_t state_q, state_d;
  srco_kind_t kind_q, kind_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [NIB_W-1:0] imm_q, imm_d;
  logic [NIB_W-1:0] acc_q, acc_d;
  logic carry_q, carry_d;
  logic zero_q, zero_d;
  logic [PCW-1:0] pc_q, pc_d;
  logic done_q, done_d;
  logic illegal_q, illegal_d;
  logic pop_d;
  logic is_mem, is_mem_wb, is_imm, is_imm_wb, is_ret, is_setc;
  logic take;
  logic [NIB_W-1:0] mem_rd;
  logic [NIB_W-1:0] subtrahend;
  logic [NIB_W:0] diff;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [NIB_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  // Operand address for the read at the accepting edge
  logic [ADDR_W-1:0] op_addr;

  // ********************************************************************
  // Decode
  // ********************************************************************
  // Prefix compares; the lower bits are operand fields
  // Return and set-carry ignore their low bits
  assign is_mem = instr[INSTR_W-1:MEM_OP_LSB] == OP_SUB_MEM_ACC;
  assign is_mem_wb = instr[INSTR_W-1:MEM_OP_LSB] == OP_SUB_MEM_WB;
  assign is_imm = instr[INSTR_W-1:IMM_OP_LSB] == OP_SUB_IMM_ACC;
  assign is_imm_wb = instr[INSTR_W-1:IMM_OP_LSB] == OP_SUB_IMM_WB;
  assign is_ret = instr[INSTR_W-1:RET_OP_LSB] == OP_RETURN;
  assign is_setc = instr[INSTR_W-1:SETC_OP_LSB] == OP_SET_CARRY;
  assign instr_ready = state_q == SRCO_IDLE;
  assign take = instr_valid && instr_ready;
  // Working registers sit in the bottom sixteen nibbles of data memory
  assign op_addr = (is_imm || is_imm_wb) ? {3'h0, instr[WR_LSB+:NIB_W]} : instr[ADDR_W-1:0];

  // ********************************************************************
  // Subtractor
  // ********************************************************************
  // Operand minus subtrahend minus carry, one extra bit catches the borrow
  // Carry enters as a borrow-in and is subtracted, not inverted
  assign subtrahend = (kind_q == SRCO_K_IMM || kind_q == SRCO_K_IMM_WB) ? imm_q : acc_q;
  assign diff = {1'b0, mem_rd} - {1'b0, subtrahend} - {{NIB_W{1'b0}}, carry_q};

  // ********************************************************************
  // Memory port muxing
  // ********************************************************************
  // Write-back beats an outside load; loads only land while idle
  // A load to the operand in the accepting cycle is read stale, but the read state reads it again before use
  always_comb begin
    rd_addr = addr_q;
    if (take) begin
      rd_addr = op_addr;
    end
    wr_en = 1'b0;
    wr_addr = load_addr;
    wr_data = load_data;
    if (state_q == SRCO_EXEC && (kind_q == SRCO_K_MEM_WB || kind_q == SRCO_K_IMM_WB)) begin
      wr_en = 1'b1;
      wr_addr = addr_q;
      wr_data = diff[NIB_W-1:0];
    end else if (load_en && state_q == SRCO_IDLE) begin
      wr_en = 1'b1;
    end
  end

  // Read address is driven at the accepting edge, so data is ready in the read state
  srco_data_mem #(
    .WIDTH(NIB_W),
    .AW(ADDR_W)
  ) u_mem (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data_q(mem_rd)
  );

  // ********************************************************************
  // Sequencer and architectural state, next values
  // ********************************************************************
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    addr_d = addr_q;
    imm_d = imm_q;
    acc_d = acc_q;
    carry_d = carry_q;
    zero_d = zero_q;
    pc_d = pc_q;
    done_d = 1'b0;
    illegal_d = 1'b0;
    pop_d = 1'b0;
    // Return and set-carry finish at the accepting edge
    unique case (state_q)
      SRCO_IDLE: begin
        if (take) begin
          if (is_ret) begin
            pc_d = stack_top;
            pop_d = 1'b1;
            done_d = 1'b1;
          end else if (is_setc) begin
            carry_d = 1'b1;
            done_d = 1'b1;
          end else if (is_mem || is_mem_wb) begin
            kind_d = is_mem ? SRCO_K_MEM : SRCO_K_MEM_WB;
            addr_d = op_addr;
            state_d = SRCO_READ;
          end else if (is_imm || is_imm_wb) begin
            kind_d = is_imm ? SRCO_K_IMM : SRCO_K_IMM_WB;
            addr_d = op_addr;
            imm_d = instr[IMM_LSB+:NIB_W];
            state_d = SRCO_READ;
          end else begin
            illegal_d = 1'b1; // Not ours; flagged, no state change
            done_d = 1'b1;
          end
        end
      end
      SRCO_READ: begin
        state_d = SRCO_EXEC; // Memory data lands this cycle
      end
      SRCO_EXEC: begin
        // Result, flags and any write-back all land on this edge
        acc_d = diff[NIB_W-1:0];
        zero_d = diff[NIB_W-1:0] == 4'h0;
        carry_d = ~diff[NIB_W];
        done_d = 1'b1;
        kind_d = SRCO_K_NONE;
        state_d = SRCO_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= SRCO_IDLE;
      kind_q <= SRCO_K_NONE;
      addr_q <= ADDR_RST;
      imm_q <= IMM_RST;
      acc_q <= ACC_RST;
      carry_q <= CARRY_RST;
      zero_q <= ZERO_RST;
      pc_q <= PC_RST;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      addr_q <= addr_d;
      imm_q <= imm_d;
      acc_q <= acc_d;
      carry_q <= carry_d;
      zero_q <= zero_d;
      pc_q <= pc_d;
      done_q <= done_d;
      illegal_q <= illegal_d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign stack_pop = pop_d; // Combinational, with the accepting edge
  // State outputs come straight from flip-flops
  assign done = done_q;
  assign illegal = illegal_q;
  assign accumulator = acc_q;
  assign carry_flag = carry_q;
  assign zero_flag = zero_q;
  assign pc = pc_q;

endmodule

// >>> core/srco_pkg.sv
// Purpose: Shared constants for the subtract, return and set-carry unit
// Assumes: 16-bit instruction word, 128 x 4 data memory, 11-bit program counter
// Notes: Working registers are the first sixteen data memory nibbles
package srco_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int NIB_W = 4;
  localparam int ADDR_W = 7;
  localparam int PC_W = 11;
  localparam int INSTR_W = 16;

  // ********************************************************************
  // Opcode prefixes and field positions
  // ********************************************************************
  localparam logic [8:0] OP_SUB_MEM_ACC = 9'h014;  // 0 0000 1010 0
  localparam logic [8:0] OP_SUB_MEM_WB = 9'h016;   // 0 0000 1011 0
  localparam logic [7:0] OP_SUB_IMM_ACC = 8'h0E;
  localparam logic [7:0] OP_SUB_IMM_WB = 8'h0F;
  localparam logic [6:0] OP_RETURN = 7'h01;
  localparam logic [12:0] OP_SET_CARRY = 13'h0A00;
  localparam int MEM_OP_LSB = 7;
  localparam int IMM_OP_LSB = 8;
  localparam int RET_OP_LSB = 9;
  localparam int SETC_OP_LSB = 3;
  localparam int IMM_LSB = 4;
  localparam int WR_LSB = 0;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [NIB_W-1:0] ACC_RST = 4'h0;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic CARRY_RST = 1'b0;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [NIB_W-1:0] IMM_RST = 4'h0;

  // ********************************************************************
  // Sequencer states and operation kinds
  // ********************************************************************
  typedef enum logic [1:0] {SRCO_IDLE, SRCO_READ, SRCO_EXEC} srco_state_t;
  typedef enum logic [2:0] {
    SRCO_K_NONE, SRCO_K_MEM, SRCO_K_MEM_WB, SRCO_K_IMM, SRCO_K_IMM_WB
  } srco_kind_t;

endpackage
